// file: hdl/mmssa_pkg.sv
package mmssa_pkg;
    // register byte addresses
    localparam logic [31:0] A_MGMT_COMMAND  = 32'hFF80_0424;
    localparam logic [31:0] A_MGMT_ADDRESS  = 32'hFF80_0428;
    localparam logic [31:0] A_MGMT_WRITE    = 32'hFF80_042C;
    localparam logic [31:0] A_READ_RESULT   = 32'hFF80_0430;
    localparam logic [31:0] A_PROGRESS      = 32'hFF80_0434;
    localparam logic [31:0] A_LINK_STATUS   = 32'hFF80_0438;
    localparam logic [31:0] A_STATION_UPPER = 32'hFF80_0440;
    localparam logic [31:0] A_STATION_MID   = 32'hFF80_0444;
    localparam logic [31:0] A_STATION_LOWER = 32'hFF80_0448;
    // field positions
    localparam int CMD_READ_BIT     = 0;
    localparam int CMD_SCAN_BIT     = 1;
    localparam int FLAG_BUSY_BIT    = 0;
    localparam int FLAG_SCAN_BIT    = 1;
    localparam int FLAG_PENDING_BIT = 2;
    localparam int DEV_LSB          = 8;
    localparam int DEV_MSB          = 12;
    localparam int REG_LSB          = 0;
    localparam int REG_MSB          = 4;
    // reset values
    localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    // timing: mdc no faster than its limit, half period rounded up
    localparam int CLK_FREQ_KHZ     = 250000;
    localparam int MDC_MAX_FREQ_KHZ = 2500;
    localparam int MDC_HALF_CYC     = (CLK_FREQ_KHZ + 2 * MDC_MAX_FREQ_KHZ - 1)
                                      / (2 * MDC_MAX_FREQ_KHZ);
    // management frame layout
    localparam logic [5:0]  FRAME_LAST      = 6'h3F;
    localparam logic [5:0]  READ_DRIVE_BITS = 6'h2E;
    localparam logic [5:0]  DATA_FIRST_BIT  = 6'h30;
    localparam logic [31:0] PREAMBLE        = 32'hFFFF_FFFF;
    localparam logic [1:0]  FRAME_START     = 2'h1;
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [1:0]  TA_WRITE        = 2'h2;
    localparam logic [1:0]  TA_READ         = 2'h3;
    localparam logic [15:0] READ_FILL       = 16'hFFFF;
    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // serial link status as it arrives
    typedef struct packed {
        logic clash;
        logic jabber;
        logic link;
        logic duplex;
        logic speed;
    } mmssa_link_t;
    // management engine states
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} mmssa_state_t;
endpackage

// file: hdl/mmssa_sync.sv
`timescale 1ns/10ps
module mmssa_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    // three-flop chain per bit, output flop moves once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_q;  // first stage, read only by s2_q
            logic s2_q;  // second stage
            logic s3_q;  // third stage
            // chain of three
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_q <= 1'h0;
                    s2_q <= 1'h0;
                    s3_q <= 1'h0;
                end else begin
                    s1_q <= d_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // agreement filter
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    q_o[g] <= 1'h0;
                end else if (s2_q == s3_q) begin
                    q_o[g] <= s3_q;
                end
            end
        end
    endgenerate
endmodule

// file: hdl/mmssa_top.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - read result word sits in low half
// - pending flag high until read data valid
// - scan flag high while continuous reads run
// - busy high for whole management cycle
// - clash bit shows phy seen in mac-to-mac
// - jabber bit shows jabber on link
// - link bit shows link good
// - duplex bit one means full duplex
// - speed bit one means 100, zero 10
// - received address compared with station address
// - upper register holds address bits 47:32
// - middle register holds address bits 31:16
// - lower register holds address bits 15:0
// - read command starts one read cycle
// - scan command repeats reads until cleared
// - write-data write launches a write cycle
// - five-bit device and register address fields
module mmssa_top #(
    parameter int MDC_HALF = mmssa_pkg::MDC_HALF_CYC
) (
    input  wire logic                   CLK_I,
    input  wire logic                   RESET_N_I,
    input  wire logic [31:0]            AXI_AWADDR_I,
    input  wire logic                   AXI_AWVALID_I,
    output logic                        AXI_AWREADY_O,
    input  wire logic [31:0]            AXI_WDATA_I,
    input  wire logic [3:0]             AXI_WSTRB_I,
    input  wire logic                   AXI_WVALID_I,
    output logic                        AXI_WREADY_O,
    output logic [1:0]                  AXI_BRESP_O,
    output logic                        AXI_BVALID_O,
    input  wire logic                   AXI_BREADY_I,
    input  wire logic [31:0]            AXI_ARADDR_I,
    input  wire logic                   AXI_ARVALID_I,
    output logic                        AXI_ARREADY_O,
    output logic [31:0]                 AXI_RDATA_O,
    output logic [1:0]                  AXI_RRESP_O,
    output logic                        AXI_RVALID_O,
    input  wire logic                   AXI_RREADY_I,
    output logic                        MDC_O,
    input  wire logic                   MDIO_I,
    output logic                        MDIO_O,
    output logic                        MDIO_OE_O,
    input  wire mmssa_pkg::mmssa_link_t LINK_STATUS_I,
    input  wire logic [47:0]            RX_DA_I,
    input  wire logic                   RX_DA_VALID_I,
    output logic                        ADDR_MATCH_O,
    output logic                        ADDR_MATCH_VALID_O,
    output logic [47:0]                 STATION_ADDR_O
);
    import mmssa_pkg::*;

    localparam logic [7:0] DIV_LAST = 8'(MDC_HALF - 1);  // divider wrap

    logic [31:0]  aw_addr_q;     // held write address
    logic         aw_have_q;     // write address taken
    logic [31:0]  w_data_q;      // held write data
    logic [3:0]   w_strb_q;      // held byte enables
    logic         w_have_q;      // write data taken
    logic         do_wr;         // write performed this cycle
    logic         wr_mapped;     // write address decodes
    logic [31:0]  rd_word;       // read mux output
    logic         rd_mapped;     // read address decodes
    logic         cmd_read_q;    // stored read command bit
    logic         cmd_scan_q;    // stored scan command bit
    logic [4:0]   phy_device_select_q;    // phy device field
    logic [4:0]   phy_register_select_q;  // phy register field
    logic [15:0]  mgmt_write_word_q;      // write-cycle data
    logic [15:0]  mgmt_read_word_q;       // last read result
    logic         rd_pend_q;     // single read requested
    logic         wr_pend_q;     // write cycle requested
    logic         read_result_pending_q;  // read not yet valid
    logic [47:0]  station_q;     // station address
    mmssa_state_t state_q;       // engine state
    logic         busy;          // cycle under way
    logic [7:0]   div_q;         // mdc divider
    logic         mdc_q;         // mdc level
    logic         tick;          // mdc half period done
    logic         rise;          // mdc about to rise
    logic         fall;          // mdc about to fall
    logic [5:0]   bit_q;         // frame bit index
    logic [63:0]  tx_q;          // outgoing frame
    logic [15:0]  rd_sh_q;       // incoming data
    logic         mdio_o_q;      // mdio drive value
    logic         mdio_oe_q;     // mdio drive enable
    logic         mdio_s;        // synchronised mdio
    logic         start_wr;      // launch write frame
    logic         start_rd;      // launch read frame
    logic         last_fall;     // frame ends
    mmssa_link_t  link_s;        // synchronised link status
    logic         match_q;       // address compare result
    logic         match_v_q;     // compare result valid

    // mdio and link status pins pass the three-flop filter
    mmssa_sync #(.WIDTH(1)) u_sync_mdio (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .d_i     (MDIO_I),
        .q_o     (mdio_s)
    );
    mmssa_sync #(.WIDTH($bits(mmssa_link_t))) u_sync_link (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .d_i     (LINK_STATUS_I),
        .q_o     (link_s)
    );

    // merge byte lanes into a 16-bit field
    function automatic logic [15:0] lane16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  strb);
        logic [15:0] r;
        r = old_v;
        if (strb[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    // write address channel
    assign AXI_AWREADY_O = !aw_have_q && !AXI_BVALID_O;
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_have_q <= 1'h0;
            aw_addr_q <= '0;
        end else if (AXI_AWVALID_I && AXI_AWREADY_O) begin
            aw_have_q <= 1'h1;
            aw_addr_q <= AXI_AWADDR_I;
        end else if (do_wr) begin
            aw_have_q <= 1'h0;
        end
    end

    // write data channel
    assign AXI_WREADY_O = !w_have_q && !AXI_BVALID_O;
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            w_have_q <= 1'h0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (AXI_WVALID_I && AXI_WREADY_O) begin
            w_have_q <= 1'h1;
            w_data_q <= AXI_WDATA_I;
            w_strb_q <= AXI_WSTRB_I;
        end else if (do_wr) begin
            w_have_q <= 1'h0;
        end
    end

    // write decode, read-only addresses accept and ignore
    assign do_wr = aw_have_q && w_have_q && !AXI_BVALID_O;
    always_comb begin
        unique case (aw_addr_q)
            A_MGMT_COMMAND, A_MGMT_ADDRESS, A_MGMT_WRITE,
            A_READ_RESULT, A_PROGRESS, A_LINK_STATUS,
            A_STATION_UPPER, A_STATION_MID, A_STATION_LOWER: wr_mapped = 1'h1;
            default: wr_mapped = 1'h0;
        endcase
    end

    // write response channel
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            AXI_BVALID_O <= 1'h0;
            AXI_BRESP_O  <= RESP_OKAY;
        end else if (do_wr) begin
            AXI_BVALID_O <= 1'h1;
            AXI_BRESP_O  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (AXI_BREADY_I) begin
            AXI_BVALID_O <= 1'h0;
        end
    end

    // read mux, reserved bits zero
    always_comb begin
        rd_word   = '0;
        rd_mapped = 1'h1;
        unique case (AXI_ARADDR_I)
            A_MGMT_COMMAND: begin
                rd_word[CMD_READ_BIT] = cmd_read_q;
                rd_word[CMD_SCAN_BIT] = cmd_scan_q;
            end
            A_MGMT_ADDRESS: begin
                rd_word[DEV_MSB:DEV_LSB] = phy_device_select_q;
                rd_word[REG_MSB:REG_LSB] = phy_register_select_q;
            end
            A_MGMT_WRITE:    rd_word = 32'(mgmt_write_word_q);
            A_READ_RESULT:   rd_word = 32'(mgmt_read_word_q);
            A_PROGRESS: begin
                rd_word[FLAG_BUSY_BIT]    = busy;
                rd_word[FLAG_SCAN_BIT]    = cmd_scan_q;
                rd_word[FLAG_PENDING_BIT] = read_result_pending_q;
            end
            A_LINK_STATUS:   rd_word = 32'(link_s);
            A_STATION_UPPER: rd_word = 32'(station_q[47:32]);
            A_STATION_MID:   rd_word = 32'(station_q[31:16]);
            A_STATION_LOWER: rd_word = 32'(station_q[15:0]);
            default:         rd_mapped = 1'h0;
        endcase
    end

    // read channel, one-cycle registered answer
    assign AXI_ARREADY_O = !AXI_RVALID_O;
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            AXI_RVALID_O <= 1'h0;
            AXI_RDATA_O  <= '0;
            AXI_RRESP_O  <= RESP_OKAY;
        end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
            AXI_RVALID_O <= 1'h1;
            AXI_RDATA_O  <= rd_word;
            AXI_RRESP_O  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (AXI_RREADY_I) begin
            AXI_RVALID_O <= 1'h0;
        end
    end

    // command, address and write-data registers
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cmd_read_q            <= 1'h0;
            cmd_scan_q            <= 1'h0;
            phy_device_select_q   <= '0;
            phy_register_select_q <= '0;
            mgmt_write_word_q     <= WORD_RESET;
        end else if (do_wr) begin
            // low lane carries the command bits and register field
            if (w_strb_q[0] && aw_addr_q == A_MGMT_COMMAND) begin
                cmd_read_q <= w_data_q[CMD_READ_BIT];
                cmd_scan_q <= w_data_q[CMD_SCAN_BIT];
            end
            if (w_strb_q[0] && aw_addr_q == A_MGMT_ADDRESS) begin
                phy_register_select_q <= w_data_q[REG_MSB:REG_LSB];
            end
            // device field sits in the second lane
            if (w_strb_q[1] && aw_addr_q == A_MGMT_ADDRESS) begin
                phy_device_select_q <= w_data_q[DEV_MSB:DEV_LSB];
            end
            if (aw_addr_q == A_MGMT_WRITE) begin
                mgmt_write_word_q <= lane16(mgmt_write_word_q, w_data_q[15:0],
                                            w_strb_q[1:0]);
            end
        end
    end

    // request flags, a new request wins over consumption
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_pend_q <= 1'h0;
            wr_pend_q <= 1'h0;
        end else begin
            if (do_wr && w_strb_q[0] && aw_addr_q == A_MGMT_COMMAND
                && w_data_q[CMD_READ_BIT]) begin
                rd_pend_q <= 1'h1;
            end else if (start_rd) begin
                rd_pend_q <= 1'h0;
            end
            if (do_wr && aw_addr_q == A_MGMT_WRITE) begin
                wr_pend_q <= 1'h1;
            end else if (start_wr) begin
                wr_pend_q <= 1'h0;
            end
        end
    end

    // station address with byte lanes
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            station_q <= STATION_RESET;
        end else if (do_wr) begin
            unique case (aw_addr_q)
                A_STATION_UPPER: station_q[47:32] <= lane16(station_q[47:32],
                    w_data_q[15:0], w_strb_q[1:0]);
                A_STATION_MID:   station_q[31:16] <= lane16(station_q[31:16],
                    w_data_q[15:0], w_strb_q[1:0]);
                A_STATION_LOWER: station_q[15:0]  <= lane16(station_q[15:0],
                    w_data_q[15:0], w_strb_q[1:0]);
                default: ;
            endcase
        end
    end
    assign STATION_ADDR_O = station_q;

    // destination compare against station address
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            match_q   <= 1'h0;
            match_v_q <= 1'h0;
        end else begin
            match_v_q <= RX_DA_VALID_I;
            match_q   <= RX_DA_VALID_I && (RX_DA_I == station_q);
        end
    end
    assign ADDR_MATCH_O       = match_q;
    assign ADDR_MATCH_VALID_O = match_v_q;

    // engine launch, write before read
    assign busy      = (state_q != ST_IDLE);
    assign start_wr  = (state_q == ST_IDLE) && wr_pend_q;
    assign start_rd  = (state_q == ST_IDLE) && !wr_pend_q && (rd_pend_q || cmd_scan_q);
    assign last_fall = fall && (bit_q == FRAME_LAST);

    // mdc divider, runs only during a frame
    assign tick = busy && (div_q == DIV_LAST);
    assign rise = tick && !mdc_q;
    assign fall = tick && mdc_q;
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            div_q <= '0;
            mdc_q <= 1'h0;
        end else if (!busy || tick) begin
            div_q <= '0;
            mdc_q <= busy && !mdc_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign MDC_O = mdc_q;

    // engine state
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= ST_IDLE;
        end else if (start_wr) begin
            state_q <= ST_WRITE;
        end else if (start_rd) begin
            state_q <= ST_READ;
        end else if (last_fall) begin
            state_q <= ST_IDLE;
        end
    end

    // frame shifter, bits change as mdc falls
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tx_q      <= '0;
            bit_q     <= '0;
            mdio_o_q  <= 1'h0;
            mdio_oe_q <= 1'h0;
        end else if (start_wr || start_rd) begin
            tx_q <= {PREAMBLE, FRAME_START, start_wr ? OP_WRITE : OP_READ,
                     phy_device_select_q, phy_register_select_q,
                     start_wr ? TA_WRITE : TA_READ,
                     start_wr ? mgmt_write_word_q : READ_FILL};
            bit_q     <= '0;
            mdio_o_q  <= PREAMBLE[31];
            mdio_oe_q <= 1'h1;
        end else if (last_fall) begin
            mdio_o_q  <= 1'h0;
            mdio_oe_q <= 1'h0;
        end else if (fall) begin
            tx_q      <= {tx_q[62:0], 1'h0};
            bit_q     <= bit_q + 6'h01;
            mdio_o_q  <= tx_q[62];
            mdio_oe_q <= (state_q == ST_WRITE)
                         || ((bit_q + 6'h01) < READ_DRIVE_BITS);
        end
    end
    assign MDIO_O    = mdio_o_q;
    assign MDIO_OE_O = mdio_oe_q;

    // read data sampled as mdc rises
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_sh_q <= '0;
        end else if (rise && state_q == ST_READ && bit_q >= DATA_FIRST_BIT) begin
            rd_sh_q <= {rd_sh_q[14:0], mdio_s};
        end
    end

    // read result and not-valid flag
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mgmt_read_word_q      <= WORD_RESET;
            read_result_pending_q <= 1'h0;
        end else if (start_rd) begin
            read_result_pending_q <= 1'h1;
        end else if (last_fall && state_q == ST_READ) begin
            mgmt_read_word_q      <= rd_sh_q;
            read_result_pending_q <= 1'h0;
        end
    end

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_read_start;
        start_rd ##1 (state_q == ST_READ);
    endsequence
    sequence s_read_hold;
        (read_result_pending_q && busy) [*8];
    endsequence

    a_result_word: assert property (
        (AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == A_READ_RESULT)
        |=> AXI_RVALID_O && AXI_RDATA_O == 32'($past(mgmt_read_word_q)))
        else $error("read result word wrong");
    a_pending_read: assert property (
        s_read_start |-> s_read_hold)
        else $error("pending flag dropped early");
    a_scan_flag: assert property (
        (AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == A_PROGRESS)
        |=> AXI_RDATA_O[FLAG_SCAN_BIT] == $past(cmd_scan_q)
            && AXI_RDATA_O[FLAG_BUSY_BIT] == $past(busy))
        else $error("progress flags wrong");
    a_busy_end: assert property (
        $fell(busy) |-> $past(fall) && $past(bit_q) == FRAME_LAST)
        else $error("busy ended before frame end");
    a_link_bits: assert property (
        (AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I == A_LINK_STATUS)
        |=> AXI_RDATA_O == 32'($past(link_s)))
        else $error("link status bits wrong");
    a_addr_match: assert property (
        (RX_DA_VALID_I && RX_DA_I == station_q) |=> ADDR_MATCH_O && ADDR_MATCH_VALID_O)
        else $error("station match missed");
    a_station_upper: assert property (
        (do_wr && aw_addr_q == A_STATION_UPPER && w_strb_q[1:0] == 2'h3)
        |=> station_q[47:32] == $past(w_data_q[15:0]))
        else $error("upper station bytes not stored");
    a_station_mid: assert property (
        (do_wr && aw_addr_q == A_STATION_MID && w_strb_q[1:0] == 2'h3)
        |=> station_q[31:16] == $past(w_data_q[15:0]))
        else $error("middle station bytes not stored");
    a_station_lower: assert property (
        (do_wr && aw_addr_q == A_STATION_LOWER && w_strb_q[1:0] == 2'h3)
        |=> station_q[15:0] == $past(w_data_q[15:0]))
        else $error("lower station bytes not stored");
    a_scan_repeat: assert property (
        (state_q == ST_IDLE && cmd_scan_q && !wr_pend_q) |=> state_q == ST_READ)
        else $error("scan read not launched");
    a_write_launch: assert property (
        (state_q == ST_IDLE && wr_pend_q) |=> state_q == ST_WRITE
            && tx_q[15:0] == $past(mgmt_write_word_q))
        else $error("write cycle not launched");
    a_frame_fields: assert property (
        (start_rd || start_wr) |=> tx_q[27:23] == $past(phy_device_select_q)
            && tx_q[22:18] == $past(phy_register_select_q))
        else $error("frame address fields wrong");
    a_read_release: assert property (
        (state_q == ST_READ && bit_q >= READ_DRIVE_BITS) |-> !MDIO_OE_O)
        else $error("mdio driven in read turnaround");
endmodule

// file: verification/mmssa_phy_model.sv
`timescale 1ns/10ps
module mmssa_phy_model #(
    parameter logic [15:0] WORD = 16'hA5C3
) (
    input  wire logic   rst_n_i,
    input  wire logic   mdc_i,
    input  wire logic   mdio_i,
    output logic        mdio_o,
    output logic        mdio_oe_o,
    output logic [63:0] frame_o
);
    logic [5:0] n_q;  // rises seen, wraps per frame
    logic       rd_q; // opcode was read
    // sample the wire on mdc rise
    always_ff @(posedge mdc_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n_q     <= 6'h00;
            rd_q    <= 1'b0;
            frame_o <= 64'h0;
        end else begin
            n_q     <= n_q + 6'h01;
            frame_o <= {frame_o[62:0], mdio_i};
            if (n_q == 6'h23) rd_q <= {frame_o[0], mdio_i} == 2'h2;
        end
    end
    // turnaround zero then data, msb first, after mdc fall
    always_ff @(negedge mdc_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mdio_oe_o <= 1'b0;
            mdio_o    <= 1'b0;
        end else begin
            mdio_oe_o <= rd_q && n_q >= 6'h2F;
            mdio_o    <= n_q != 6'h2F && WORD[4'(6'h3F - n_q)];
        end
    end
endmodule

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
    import mmssa_pkg::*;
    localparam logic [15:0] RW = 16'hA5C3; // phy read word
    logic        clk = 0, rst_n = 0, aw_v = 0, w_v = 0, ar_v = 0, rx_v = 0;
    logic        awr, wrr, bv, arr, rv, mdc, mo, moe, p_d, p_oe, m, mv, mdio;
    logic [31:0] aw_a = 0, w_d = 0, ar_a = 0, rdat, v;
    logic [1:0]  br, rr;
    logic [47:0] rx = 0, sa;
    logic [63:0] frm;
    mmssa_link_t lnk = '0;
    int          errors = 0, n_compared = 0;
    assign mdio = moe ? mo : p_oe ? p_d : 1'b1; // pull-up when released
    mmssa_top #(.MDC_HALF(10)) i_mmssa_top (.CLK_I(clk), .RESET_N_I(rst_n), .AXI_AWADDR_I(aw_a),
        .AXI_AWVALID_I(aw_v), .AXI_AWREADY_O(awr), .AXI_WDATA_I(w_d), .AXI_WSTRB_I(4'hF),
        .AXI_WVALID_I(w_v), .AXI_WREADY_O(wrr), .AXI_BRESP_O(br), .AXI_BVALID_O(bv),
        .AXI_BREADY_I(1'b1), .AXI_ARADDR_I(ar_a), .AXI_ARVALID_I(ar_v), .AXI_ARREADY_O(arr),
        .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr), .AXI_RVALID_O(rv), .AXI_RREADY_I(1'b1),
        .MDC_O(mdc), .MDIO_I(mdio), .MDIO_O(mo), .MDIO_OE_O(moe), .LINK_STATUS_I(lnk),
        .RX_DA_I(rx), .RX_DA_VALID_I(rx_v), .ADDR_MATCH_O(m), .ADDR_MATCH_VALID_O(mv),
        .STATION_ADDR_O(sa));
    mmssa_phy_model #(.WORD(RW)) i_mmssa_phy_model (.rst_n_i(rst_n), .mdc_i(mdc),
        .mdio_i(mdio), .mdio_o(p_d), .mdio_oe_o(p_oe), .frame_o(frm));
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [63:0] g, e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // write: address and data together, released as each is taken
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
        aw_a <= a;
        w_d  <= d;
        aw_v <= 1'b1;
        w_v  <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) aw_v <= 1'b0;
            if (wrr) w_v <= 1'b0;
        end while (!bv);
        chk(br, r);
    endtask
    // read into v and check the response code
    task automatic rd(input logic [31:0] a, input logic [1:0] r);
        ar_a <= a;
        ar_v <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) ar_v <= 1'b0;
        end while (!rv);
        v = rdat;
        chk(rr, r);
    endtask
    task automatic rc(input logic [31:0] a, e);
        rd(a, RESP_OKAY);
        chk(v, e);
    endtask
    // poll until the engine is idle
    task automatic idle();
        for (int i = 0; i < 2000 && (i == 0 || v[FLAG_BUSY_BIT] !== 1'b0); i++)
            rd(A_PROGRESS, RESP_OKAY);
        chk(v[FLAG_BUSY_BIT], 1'b0);
    endtask
    task automatic t_station();
        rc(A_STATION_UPPER, 32'h0);
        wr(A_STATION_UPPER, 32'hFFFF_0211, RESP_OKAY);
        wr(A_STATION_MID, 32'hFFFF_3344, RESP_OKAY);
        wr(A_STATION_LOWER, 32'hFFFF_5566, RESP_OKAY);
        rc(A_STATION_UPPER, 32'h0211);
        rc(A_STATION_MID, 32'h3344);
        rc(A_STATION_LOWER, 32'h5566);
        chk(sa, 48'h0211_3344_5566);
        for (int i = 0; i < 2; i++) begin
            rx   <= 48'h0211_3344_5566 ^ 48'(i);
            rx_v <= 1'b1;
            @(posedge clk);
            rx_v <= 1'b0;
            #1 chk({mv, m}, {1'b1, i == 0});
            @(posedge clk);
        end
        wr(32'hFF80_0500, 32'h1, RESP_SLVERR);
        rd(32'hFF80_0500, RESP_SLVERR);
        chk(v, 32'h0);
    endtask
    task automatic t_link();
        for (int i = 0; i < 5; i++) begin
            lnk <= mmssa_link_t'(5'(1 << i));
            repeat (8) @(posedge clk);
            rc(A_LINK_STATUS, 32'(1 << i));
        end
    endtask
    task automatic t_mgmt();
        wr(A_MGMT_ADDRESS, 32'h0302, RESP_OKAY);
        wr(A_MGMT_COMMAND, 32'h1, RESP_OKAY);
        rc(A_PROGRESS, 32'h5);
        idle();
        chk(v[FLAG_PENDING_BIT], 1'b0);
        rc(A_READ_RESULT, {16'h0, RW});
        chk(frm, {PREAMBLE, FRAME_START, OP_READ, 10'h062, 2'h2, RW});
        wr(A_MGMT_WRITE, 32'hBEEF, RESP_OKAY);
        idle();
        chk(frm, {PREAMBLE, FRAME_START, OP_WRITE, 10'h062, TA_WRITE, 16'hBEEF});
        wr(A_READ_RESULT, 32'h0, RESP_OKAY);
        wr(A_MGMT_COMMAND, 32'h2, RESP_OKAY);
        rd(A_PROGRESS, RESP_OKAY);
        chk(v[1:0], 2'h3);
        wr(A_MGMT_COMMAND, 32'h0, RESP_OKAY);
        idle();
        rc(A_READ_RESULT, {16'h0, RW});
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_station();
        t_link();
        t_mgmt();
        tally_and_finish();
    end
    // hang guard, well beyond the few thousand cycles needed
    initial begin
        #80000;
        errors++;
        tally_and_finish();
    end
endmodule
